// ---- design/qdd_decoder.sv ----
// Quad DAC serial command decoder, top level
`timescale 1ns/100ps
module qdd_decoder (
	// System clock and reset
	input wire logic clock_i,
	input wire logic rst_n_i,
	// Serial link
	input wire logic sclk_i,
	input wire logic cs_n_i,
	input wire logic din_i,
	output logic dout_o,
	// Hardware control pins
	input wire logic load_dac_n_i,
	input wire logic clear_n_i,
	input wire logic power_down_permit_i,
	// DAC codes
	output logic [qdd_pkg::DATA_W-1:0] dac_a_o,
	output logic [qdd_pkg::DATA_W-1:0] dac_b_o,
	output logic [qdd_pkg::DATA_W-1:0] dac_c_o,
	output logic [qdd_pkg::DATA_W-1:0] dac_d_o,
	// Status
	output logic amp_shutdown_o,
	output logic user_logic_out_o,
	output logic phase_rise_o
);

	import qdd_pkg::*;

	logic [2:0] pin_level;
	logic cs_level;
	logic load_level_n;
	logic permit_level;
	logic cs_prev_reg;
	logic cs_rise;
	logic go_reg;
	logic [WORD_W-1:0] link_word;
	logic [WORD_W-1:0] word_reg;
	logic [3:0] w_op;
	logic [1:0] w_addr;
	logic [1:0] w_ctrl;
	logic [DATA_W-1:0] w_data;
	logic data_rst_n;
	logic xfer;
	logic [N_DAC-1:0][DATA_W-1:0] inp_reg;
	logic [N_DAC-1:0][DATA_W-1:0] inp_next;
	logic [N_DAC-1:0][DATA_W-1:0] dac_reg;
	logic shdn_reg;
	logic user_reg;
	qdd_phase_t phase_reg;

	// Pin filtering

	qdd_pin_filter #(
		.W(3),
		.RST_VAL(PIN_RST)
	) u_pins (
		.clock_i(clock_i),
		.rst_n_i(rst_n_i),
		.pin_i({cs_n_i, load_dac_n_i, power_down_permit_i}),
		.level_o(pin_level)
	);

	assign cs_level = pin_level[2];
	assign load_level_n = pin_level[1];
	assign permit_level = pin_level[0];

	// Link side

	qdd_serial_link u_link (
		.sclk_i(sclk_i),
		.rst_n_i(rst_n_i),
		.cs_n_i(cs_n_i),
		.din_i(din_i),
		.dout_o(dout_o),
		.phase_rise_i(phase_reg),
		.word_o(link_word)
	);

	// Chip-select rise

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cs_prev_reg <= 1'b1;
		end else begin
			cs_prev_reg <= cs_level;
		end
	end

	assign cs_rise = cs_level & ~cs_prev_reg;

	// The word is frozen while chip select is high, so it is taken whole
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			word_reg <= '0;
		end else if (cs_rise) begin
			word_reg <= link_word;
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			go_reg <= 1'b0;
		end else begin
			go_reg <= cs_rise;
		end
	end

	assign w_op = word_reg[OP_MSB:OP_LSB];
	assign w_addr = word_reg[ADDR_MSB:ADDR_LSB];
	assign w_ctrl = word_reg[CTRL_MSB:CTRL_LSB];
	assign w_data = word_reg[DATA_MSB:DATA_LSB];

	// Data registers, cleared by reset or the clear pin

	assign data_rst_n = rst_n_i & clear_n_i;

	// NOP and other special words fall through untouched
	always_comb begin
		inp_next = inp_reg;
		if (go_reg && (w_ctrl == CTRL_LOAD_IN || w_ctrl == CTRL_LOAD_XFER)) begin
			inp_next[w_addr] = w_data;
		end
	end

	always_ff @(posedge clock_i or negedge data_rst_n) begin
		if (!data_rst_n) begin
			inp_reg <= {N_DAC{DAC_RST}};
		end else begin
			inp_reg <= inp_next;
		end
	end

	// Commands that copy every input register into its DAC register
	assign xfer = go_reg && (w_ctrl == CTRL_LOAD_XFER
		|| w_op == OP_SW_LOAD
		|| w_op == OP_PHASE_RISE
		|| w_op == OP_PHASE_FALL);

	always_ff @(posedge clock_i or negedge data_rst_n) begin
		if (!data_rst_n) begin
			dac_reg <= {N_DAC{DAC_RST}};
		end else if (go_reg && w_op == OP_LOAD_ALL) begin
			dac_reg <= {N_DAC{w_data}};
		end else if (!load_level_n || xfer) begin
			dac_reg <= inp_next;
		end
	end

	// Control state

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			shdn_reg <= SHDN_RST;
		end else if (go_reg && w_op == OP_SHUTDOWN && permit_level) begin
			shdn_reg <= 1'b1;
		end else if (go_reg && (w_op == OP_SW_LOAD || w_op == OP_LOAD_ALL)) begin
			shdn_reg <= 1'b0;
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			user_reg <= USER_RST;
		end else if (go_reg && w_op == OP_USER_LO) begin
			user_reg <= 1'b0;
		end else if (go_reg && w_op == OP_USER_HI) begin
			user_reg <= 1'b1;
		end
	end

	// Phase is held until the opposite command arrives
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			phase_reg <= QDD_PH_FALL;
		end else if (go_reg && w_op == OP_PHASE_RISE) begin
			phase_reg <= QDD_PH_RISE;
		end else if (go_reg && w_op == OP_PHASE_FALL) begin
			phase_reg <= QDD_PH_FALL;
		end
	end

	// Outputs

	assign dac_a_o = dac_reg[0];
	assign dac_b_o = dac_reg[1];
	assign dac_c_o = dac_reg[2];
	assign dac_d_o = dac_reg[3];
	assign amp_shutdown_o = shdn_reg;
	assign user_logic_out_o = user_reg;
	assign phase_rise_o = phase_reg;

	// Checks

	a_load_input_reg: assert property (@(posedge clock_i) disable iff (!data_rst_n)
		go_reg && w_ctrl == CTRL_LOAD_IN |=> inp_reg[$past(w_addr)] == $past(w_data))
		else $error("input register not loaded");

	a_load_keeps_dac: assert property (@(posedge clock_i) disable iff (!data_rst_n)
		go_reg && w_ctrl == CTRL_LOAD_IN && load_level_n |=> $stable(dac_reg))
		else $error("single load changed a DAC register");

	a_load_then_xfer: assert property (@(posedge clock_i) disable iff (!data_rst_n)
		go_reg && w_ctrl == CTRL_LOAD_XFER |=> dac_reg == inp_reg
			&& dac_reg[$past(w_addr)] == $past(w_data))
		else $error("load with transfer did not update DACs");

	a_soft_load: assert property (@(posedge clock_i) disable iff (!data_rst_n)
		go_reg && w_op == OP_SW_LOAD |=> dac_reg == $past(inp_reg) && !shdn_reg)
		else $error("software load failed");

	a_load_all_dacs: assert property (@(posedge clock_i) disable iff (!data_rst_n)
		go_reg && w_op == OP_LOAD_ALL |=> dac_reg == {N_DAC{$past(w_data)}} && !shdn_reg
			&& $stable(inp_reg))
		else $error("load all failed");

	a_shutdown_gate: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		go_reg && w_op == OP_SHUTDOWN |=> shdn_reg == ($past(permit_level) || $past(shdn_reg)))
		else $error("shutdown not gated by permit");

	a_shutdown_hold: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		!(go_reg && (w_op == OP_SHUTDOWN || w_op == OP_SW_LOAD || w_op == OP_LOAD_ALL))
			|=> $stable(shdn_reg))
		else $error("shutdown flag changed without command");

	a_user_output: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		go_reg && (w_op == OP_USER_LO || w_op == OP_USER_HI)
			|=> user_logic_out_o == ($past(w_op) == OP_USER_HI) && $stable(dac_reg))
		else $error("user output wrong");

	a_nop_quiet: assert property (@(posedge clock_i) disable iff (!data_rst_n)
		go_reg && w_op == OP_NOP && load_level_n |=> $stable(inp_reg) && $stable(dac_reg))
		else $error("no-operation changed a register");

	a_phase_set: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		go_reg && w_op == OP_PHASE_RISE |=> phase_reg == QDD_PH_RISE ##1 phase_rise_o)
		else $error("rising phase not selected");

	a_phase_clear: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		go_reg && w_op == OP_PHASE_FALL |=> phase_reg == QDD_PH_FALL)
		else $error("falling phase not selected");

	a_phase_held: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		!(go_reg && (w_op == OP_PHASE_RISE || w_op == OP_PHASE_FALL)) |=> $stable(phase_reg))
		else $error("phase changed without command");

	a_transparent: assert property (@(posedge clock_i) disable iff (!data_rst_n)
		!load_level_n && !(go_reg && w_op == OP_LOAD_ALL) |=> dac_reg == inp_reg)
		else $error("DAC registers not transparent");

	a_clear_zero: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		!clear_n_i |-> inp_reg == '0 && dac_reg == '0)
		else $error("clear did not zero registers");

	a_decode_once: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		cs_rise |=> go_reg && word_reg == $past(link_word) ##1 !go_reg)
		else $error("word not decoded at chip-select rise");

	// Phase commands also copy every input register
	a_phase_xfer: assert property (@(posedge clock_i) disable iff (!data_rst_n)
		go_reg && (w_op == OP_PHASE_RISE || w_op == OP_PHASE_FALL) |=> dac_reg == $past(inp_reg)
			&& $stable(inp_reg))
		else $error("phase command did not copy inputs to DACs");

	// State stays put between decoded words while the load pin is high
	a_input_hold: assert property (@(posedge clock_i) disable iff (!data_rst_n)
		!go_reg |=> $stable(inp_reg))
		else $error("input register changed without command");

	a_dac_hold: assert property (@(posedge clock_i) disable iff (!data_rst_n)
		!go_reg && load_level_n |=> $stable(dac_reg))
		else $error("DAC register changed without command or load");

	a_user_hold: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		!(go_reg && (w_op == OP_USER_LO || w_op == OP_USER_HI)) |=> $stable(user_logic_out_o))
		else $error("user output changed without command");

	a_word_hold: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		!cs_rise |=> $stable(word_reg))
		else $error("held word changed without chip-select rise");

	a_shutdown_refused: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		go_reg && w_op == OP_SHUTDOWN && !permit_level |=> $stable(amp_shutdown_o))
		else $error("shutdown taken without permit");

	a_shutdown_wake: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		go_reg && (w_op == OP_SW_LOAD || w_op == OP_LOAD_ALL) |=> !amp_shutdown_o)
		else $error("shutdown not left on load command");

endmodule : qdd_decoder

// ---- design/qdd_pkg.sv ----
// Shared constants for the quad DAC serial command decoder
package qdd_pkg;

	// Word layout
	localparam int WORD_W = 12;
	localparam int DATA_W = 8;
	localparam int N_DAC = 4;
	localparam int OP_MSB = 11;
	localparam int OP_LSB = 8;
	localparam int ADDR_MSB = 11;
	localparam int ADDR_LSB = 10;
	localparam int CTRL_MSB = 9;
	localparam int CTRL_LSB = 8;
	localparam int DATA_MSB = 7;
	localparam int DATA_LSB = 0;

	// Control code field
	localparam logic [1:0] CTRL_LOAD_IN = 2'h1;
	localparam logic [1:0] CTRL_LOAD_XFER = 2'h3;

	// Special commands, address and control together
	localparam logic [3:0] OP_NOP = 4'h0;
	localparam logic [3:0] OP_USER_LO = 4'h2;
	localparam logic [3:0] OP_SW_LOAD = 4'h4;
	localparam logic [3:0] OP_USER_HI = 4'h6;
	localparam logic [3:0] OP_LOAD_ALL = 4'h8;
	localparam logic [3:0] OP_PHASE_FALL = 4'hA;
	localparam logic [3:0] OP_SHUTDOWN = 4'hC;
	localparam logic [3:0] OP_PHASE_RISE = 4'hE;

	// Reset values
	localparam logic [7:0] DAC_RST = 8'h00;
	localparam logic USER_RST = 1'b0;
	localparam logic SHDN_RST = 1'b0;
	// Pin filter reset: chip select idle, load idle, permit low
	localparam logic [2:0] PIN_RST = 3'h6;

	// Serial output phase
	typedef enum logic {
		QDD_PH_FALL = 1'b0,
		QDD_PH_RISE = 1'b1
	} qdd_phase_t;

endpackage : qdd_pkg

// ---- design/qdd_pin_filter.sv ----
// Three-flop pin synchroniser with agreement filter
`timescale 1ns/100ps
module qdd_pin_filter #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	// Clock and reset
	input wire logic clock_i,
	input wire logic rst_n_i,
	// Pins and filtered levels
	input wire logic [W-1:0] pin_i,
	output logic [W-1:0] level_o
);

	logic [W-1:0] meta_reg;
	logic [W-1:0] sync_reg;
	logic [W-1:0] late_reg;
	logic [W-1:0] level_reg;
	logic [W-1:0] agree;

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			meta_reg <= RST_VAL;
			sync_reg <= RST_VAL;
			late_reg <= RST_VAL;
		end else begin
			meta_reg <= pin_i;
			sync_reg <= meta_reg;
			late_reg <= sync_reg;
		end
	end

	// A change counts once the second and third stages agree
	assign agree = ~(sync_reg ^ late_reg);

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			level_reg <= RST_VAL;
		end else begin
			level_reg <= (level_reg & ~agree) | (late_reg & agree);
		end
	end

	assign level_o = level_reg;

endmodule : qdd_pin_filter

// ---- design/qdd_serial_link.sv ----
// Serial shift path and daisy-chain output on the serial clock
`timescale 1ns/100ps
module qdd_serial_link (
	// Link clock and reset
	input wire logic sclk_i,
	input wire logic rst_n_i,
	// Serial pins
	input wire logic cs_n_i,
	input wire logic din_i,
	output logic dout_o,
	// Phase select from the system domain
	input wire logic phase_rise_i,
	// Shift register contents
	output logic [qdd_pkg::WORD_W-1:0] word_o
);

	import qdd_pkg::*;

	logic [WORD_W-1:0] shift_reg;
	logic phase_level;
	logic rise_out_reg;
	logic fall_out_reg;

	// MSB first; a longer word leaves only its last twelve bits
	always_ff @(posedge sclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			shift_reg <= '0;
		end else if (!cs_n_i) begin
			shift_reg <= {shift_reg[WORD_W-2:0], din_i};
		end
	end

	// Phase crosses on the link clock and settles in the first edges of the next frame
	qdd_pin_filter #(
		.W(1),
		.RST_VAL(QDD_PH_FALL)
	) u_phase (
		.clock_i(sclk_i),
		.rst_n_i(rst_n_i),
		.pin_i(phase_rise_i),
		.level_o(phase_level)
	);

	// Extra rising stage gives a lag of 12, the falling stage 12.5
	always_ff @(posedge sclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rise_out_reg <= 1'b0;
		end else if (!cs_n_i) begin
			rise_out_reg <= shift_reg[WORD_W-1];
		end
	end

	always_ff @(negedge sclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			fall_out_reg <= 1'b0;
		end else if (!cs_n_i) begin
			fall_out_reg <= rise_out_reg;
		end
	end

	// Passes the word on to the next device in a chain
	assign dout_o = phase_level ? rise_out_reg : fall_out_reg;
	assign word_o = shift_reg;

endmodule : qdd_serial_link

// ---- tb/qdd_master.sv ----
// Serial host model driving the link pins of the decoder
`timescale 1ns/100ps
module qdd_master (
	// Link pins
	output logic sclk_o,
	output logic cs_n_o,
	output logic din_o,
	input wire logic dout_i
);
	initial begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		din_o = 1'b0;
	end

	// Shift n bits MSB first; dout is sampled just before each rising and each falling edge
	task automatic xfer(input logic [23:0] w, input int n, output logic [23:0] rx, output logic [23:0] rx_hi);
		rx = '0;
		rx_hi = '0;
		cs_n_o = 1'b0;
		#62.5;
		for (int i = n - 1; i >= 0; i--) begin
			din_o = w[i];
			#62.5;
			rx = {rx[22:0], dout_i};
			sclk_o = 1'b1;
			#60;
			rx_hi = {rx_hi[22:0], dout_i};
			#2.5;
			sclk_o = 1'b0;
		end
		#62.5;
		cs_n_o = 1'b1;
		// Released data line shows the inverse of its last bit
		din_o = ~din_o;
	endtask : xfer
endmodule : qdd_master

// ---- tb/tb_qdd_decoder.sv ----
// Self-checking bench for the quad DAC serial command decoder
`timescale 1ns/100ps
module tb_qdd_decoder;
	import qdd_pkg::*;
	logic clock_i, rst_n_i, sclk, cs_n, din, dout;
	logic load_dac_n, clear_n, permit, shdn, user_logic_out, ph;
	logic [7:0] dac_a, dac_b, dac_c, dac_d;
	logic [7:0] inreg [4];
	logic [7:0] dac [4];
	logic [11:0] sreg;
	logic [23:0] rx, rx_hi;
	logic eshdn, eupo, eph;
	int n_mismatch = 0;
	int num_checks = 0;
	int cycles = 0;

	qdd_decoder qdd_decoder_inst (
		.clock_i(clock_i),
		.rst_n_i(rst_n_i),
		.sclk_i(sclk),
		.cs_n_i(cs_n),
		.din_i(din),
		.dout_o(dout),
		.load_dac_n_i(load_dac_n),
		.clear_n_i(clear_n),
		.power_down_permit_i(permit),
		.dac_a_o(dac_a),
		.dac_b_o(dac_b),
		.dac_c_o(dac_c),
		.dac_d_o(dac_d),
		.amp_shutdown_o(shdn),
		.user_logic_out_o(user_logic_out),
		.phase_rise_o(ph)
	);

	qdd_master qdd_master_inst (
		.sclk_o(sclk),
		.cs_n_o(cs_n),
		.din_o(din),
		.dout_i(dout)
	);

	task automatic end_sim();
		$display("Mismatches %0d, checks %0d", n_mismatch, num_checks);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : end_sim

	task automatic compare(input logic [34:0] seen, input logic [34:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask : compare

	task automatic check_all();
		compare({dac_a, dac_b, dac_c, dac_d, shdn, user_logic_out, ph},
			{dac[0], dac[1], dac[2], dac[3], eshdn, eupo, eph});
	endtask : check_all

	// Send a frame, update the expected state from the held word, then compare
	task automatic send(input logic [23:0] w, input int n);
		logic [1:0] a;
		logic [3:0] op;
		logic [7:0] d;
		for (int i = n - 1; i >= 0; i--) sreg = {sreg[10:0], w[i]};
		a = sreg[ADDR_MSB:ADDR_LSB];
		op = sreg[OP_MSB:OP_LSB];
		d = sreg[DATA_MSB:DATA_LSB];
		// Frames open off the system clock edge
		@(negedge clock_i);
		qdd_master_inst.xfer(w, n, rx, rx_hi);
		if (sreg[CTRL_LSB]) inreg[a] = d;
		if (sreg[CTRL_MSB:CTRL_LSB] == CTRL_LOAD_XFER) dac = inreg;
		case (op)
			OP_SW_LOAD, OP_PHASE_RISE, OP_PHASE_FALL: dac = inreg;
			OP_LOAD_ALL: dac = '{d, d, d, d};
			OP_USER_LO: eupo = 1'b0;
			OP_USER_HI: eupo = 1'b1;
			default: ;
		endcase
		eshdn = (op == OP_SHUTDOWN && permit) || (eshdn && op != OP_SW_LOAD && op != OP_LOAD_ALL);
		eph = (op == OP_PHASE_RISE) ? 1'b1 : (op == OP_PHASE_FALL) ? 1'b0 : eph;
		if (!load_dac_n) dac = inreg;
		repeat (12) @(negedge clock_i);
		check_all();
	endtask : send

	initial begin
		clock_i = 1'b0;
		forever #20 clock_i = ~clock_i;
	end

	always @(posedge clock_i) begin
		cycles++;
		if (cycles == 20000) begin
			n_mismatch++;
			end_sim();
		end
	end

	initial begin
		rst_n_i = 1'b0;
		load_dac_n = 1'b1;
		clear_n = 1'b1;
		permit = 1'b0;
		sreg = '0;
		eshdn = 1'b0;
		eupo = 1'b0;
		eph = 1'b0;
		foreach (inreg[i]) begin
			inreg[i] = 8'h00;
			dac[i] = 8'h00;
		end
		repeat (3) @(posedge clock_i);
		rst_n_i <= 1'b1;
		repeat (6) @(negedge clock_i);
		check_all();
		for (int i = 0; i < 4; i++) send({12'h000, 2'(i), CTRL_LOAD_IN, 8'(8'h11 * (i + 1))}, 12);
		send(24'h0004FF, 12);
		send(24'h0007A3, 12);
		send(24'h000C00, 12);
		@(posedge clock_i) permit <= 1'b1;
		send(24'h000C00, 12);
		send(24'h00085A, 12);
		send(24'h000C00, 12);
		send(24'h000400, 12);
		send(24'h000600, 12);
		send(24'h000200, 12);
		send(24'h00014C, 12);
		send(24'h000040, 12);
		send(24'h000005, 4);
		send(24'h00F32E, 16);
		send(24'h000E00, 12);
		send(24'h00015D, 12);
		send(24'hA5C000, 24);
		compare({24'h000000, rx[10:0]}, {24'h000000, 11'h52E});
		compare({24'h000000, rx_hi[10:0]}, {24'h000000, 11'h25C});
		send(24'h000A00, 12);
		send(24'h3C9A00, 24);
		compare({24'h000000, rx[10:0]}, {24'h000000, 11'h1E4});
		compare({24'h000000, rx_hi[10:0]}, {24'h000000, 11'h1E4});
		@(posedge clock_i) load_dac_n <= 1'b0;
		send(24'h000977, 12);
		@(posedge clock_i) load_dac_n <= 1'b1;
		@(posedge clock_i) clear_n <= 1'b0;
		#5;
		foreach (inreg[i]) begin
			inreg[i] = 8'h00;
			dac[i] = 8'h00;
		end
		check_all();
		@(posedge clock_i) clear_n <= 1'b1;
		send(24'h000400, 12);
		end_sim();
	end
endmodule : tb_qdd_decoder
